// ==== include/ppl_pkg.sv ====
// Purpose: Constants and types for the parallel passive configuration loader
// Assumes: mclk at 250 MHz
// Notes:   Times are kept in their own units; cycle counts derive from them
package ppl_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS       = 4;
  localparam int SETTLE_NS    = 600;
  localparam int SETTLE_CYC   = SETTLE_NS / CLK_NS;
  localparam int STAT_MIN_US  = 268;
  localparam int STAT_MIN_CYC = (STAT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STAT_TOP_US  = 1506;
  localparam int STAT_TOP_CYC = STAT_TOP_US * 1000 / CLK_NS;
  localparam int INIT_MIN_US  = 175;
  localparam int INIT_TOP_US  = 437;
  localparam int INIT_CYC     = (INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int INIT_TOP_CYC = INIT_TOP_US * 1000 / CLK_NS;
  localparam int LCLK_TOP_NS  = 10;
  localparam int UEN_CYC      = (4 * LCLK_TOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int UCLK_PERIODS = 8576;
  localparam int TAIL_EDGES   = 2;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IMG  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CNT  = 8'h0C;

  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;

  typedef struct packed {
    logic       ucl_opt;  // Init clocked by user_init_clock
    logic       id_en;    // Init-done pin enabled
    logic       sec;      // Security enabled
    logic       dec;      // Decompression enabled
    logic [1:0] wid;      // Bus width code
  } ppl_ctrl_type;

  localparam ppl_ctrl_type CTRL_RST = '0;

  // Open-drain pin enables (value is always low)
  typedef struct packed {
    logic st_oe;
    logic cd_oe;
    logic id_oe;
  } ppl_pins_type;

  typedef enum logic [2:0] {
    ST_POR   = 3'b000,
    ST_CLEAR = 3'b001,
    ST_HOLD  = 3'b010,
    ST_LOAD  = 3'b011,
    ST_TAIL  = 3'b100,
    ST_INIT  = 3'b101,
    ST_USER  = 3'b110
  } ppl_state_type;

  // Load clocks per data word
  function automatic logic [3:0] ratio_f(input ppl_ctrl_type c);
    case (c.wid)
      W16:     return c.dec ? 4'h4 : (c.sec ? 4'h2 : 4'h1);
      W32:     return c.dec ? 4'h8 : (c.sec ? 4'h4 : 4'h1);
      default: return c.dec ? 4'h2 : 4'h1;
    endcase
  endfunction

  // Data lanes that carry the image
  function automatic logic [31:0] mask_f(input logic [1:0] wid);
    case (wid)
      W16:     return 32'h0000_FFFF;
      W32:     return 32'hFFFF_FFFF;
      default: return 32'h0000_00FF;
    endcase
  endfunction

endpackage

// ==== verilog/ppl_loader.sv ====
// Purpose: Device end of a parallel passive configuration load port
// Assumes: Pins asynchronous to mclk; APB register access
// Notes:   Load clock is oversampled, so it must stay well below mclk/4
//
// What this block and the host do
// RQ1 - Clocks per word set by width, features
// RQ2 - Host clocks r load edges per word
// RQ3 - Extra edges spent decrypting and decompressing
// RQ4 - Host keeps clocking r-1 after last word
// RQ5 - Word captured on load clock rising edge
// RQ6 - Narrow modes use only low data lanes
// RQ7 - After load, data lanes user, clock ignored
// RQ8 - User mode: all lines high; request restarts
// RQ9 - Status low for power-on delay
// RQ10 - Load-complete low through whole configuration
// RQ11 - Complete after full image; two falling edges
// RQ12 - Init-done pin low until initialization ends
// RQ13 - Request low drives both lines low quickly
// RQ14 - Host holds request low two microseconds
// RQ15 - Status low 268 to 1506 microseconds
// RQ16 - Status released by 1506 after request
// RQ17 - Host waits after status before clocking
// RQ18 - Host limits load clock frequency
// RQ19 - Internal init takes 175 to 437 microseconds
// RQ20 - User init clock enabled after four periods
// RQ21 - User init takes 8576 user clock periods
// RQ22 - Host treats status low as error
//
// Local design decisions: the APB interface to the registers and the register addresses.
module ppl_loader #(
  parameter int STAT_CYC = ppl_pkg::STAT_MIN_CYC,
  parameter int INIT_CYC = ppl_pkg::INIT_CYC,
  parameter int UCLK_NUM = ppl_pkg::UCLK_PERIODS
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Configuration pins
  input  wire logic        load_clock_i,
  input  wire logic [31:0] data_i,
  input  wire logic        reprog_b_i,
  input  wire logic        status_b_i,
  input  wire logic        user_init_clock_i,
  output logic             status_b_o,
  output logic             status_b_oe_o,
  output logic             load_done_o,
  output logic             load_done_oe_o,
  output logic             init_done_o,
  output logic             init_done_oe_o,
  output logic             user_io_o,
  // Captured image words
  output logic      [31:0] word_o,
  output logic             word_valid_o
);

  // ----------------------------------------------------------------------
  // Constants and checks
  // ----------------------------------------------------------------------
  localparam logic [19:0] STAT_L = 20'(STAT_CYC);
  localparam logic [19:0] INIT_L = 20'(INIT_CYC);
  localparam logic [19:0] UEN_L  = 20'(ppl_pkg::UEN_CYC);
  localparam logic [19:0] UEND_L = 20'(ppl_pkg::UEN_CYC + UCLK_NUM);
  localparam logic [19:0] TAIL_L = 20'(ppl_pkg::TAIL_EDGES);

  // Counts must fit the 20-bit shared timer; refused at elaboration
  if (STAT_CYC < 1 || STAT_CYC > ppl_pkg::STAT_TOP_CYC
      || INIT_CYC < 1 || INIT_CYC >= (1 << 20)
      || UCLK_NUM < 1 || UCLK_NUM + ppl_pkg::UEN_CYC >= (1 << 20)) begin : g_bad_param
    $error("ppl_loader parameter out of range");
  end

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [2:0]  lclk_s;
  logic [2:0]  ucl_s;
  logic [1:0]  cfg_s;
  logic [1:0]  sts_s;
  logic [31:0] d1_q;
  logic [31:0] d2_q;

  // Two flops per pin; the third stage only feeds edge detection
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lclk_s <= '0;
      ucl_s  <= '0;
      cfg_s  <= '1;
      sts_s  <= '1;
      d1_q   <= '0;
      d2_q   <= '0;
    end else begin
      lclk_s <= {lclk_s[1:0], load_clock_i};
      ucl_s  <= {ucl_s[1:0], user_init_clock_i};
      cfg_s  <= {cfg_s[0], reprog_b_i};
      sts_s  <= {sts_s[0], status_b_i};
      d1_q   <= data_i;
      d2_q   <= d1_q;
    end
  end

  wire lrise_w = lclk_s[1] & ~lclk_s[2];
  wire lfall_w = ~lclk_s[1] & lclk_s[2];
  wire urise_w = ucl_s[1] & ~ucl_s[2];

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  ppl_pkg::ppl_ctrl_type  ctrl_q;
  ppl_pkg::ppl_state_type st_q;
  ppl_pkg::ppl_state_type st_d;
  ppl_pkg::ppl_pins_type  pins_q;
  ppl_pkg::ppl_pins_type  pins_d;
  logic [31:0] img_q;
  logic [31:0] wcnt_q;
  logic [19:0] cnt_q;
  logic [3:0]  ph_q;
  logic [31:0] word_q;
  logic        wv_q;
  logic        user_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire        setup_w = psel_i & ~penable_i;
  wire        acc_w   = psel_i & penable_i & pready_q;
  wire        hit_w   = (paddr_i == ppl_pkg::OFS_CTRL) | (paddr_i == ppl_pkg::OFS_IMG)
                      | (paddr_i == ppl_pkg::OFS_STAT) | (paddr_i == ppl_pkg::OFS_CNT);
  wire        wr_w    = acc_w & pwrite_i & ~pslverr_q;
  wire [31:0] stat_w  = {26'h0, user_q, ~pins_q.cd_oe, sts_s[1], st_q};
  wire [31:0] rd_w    = (paddr_i == ppl_pkg::OFS_CTRL) ? 32'(ctrl_q)
                      : (paddr_i == ppl_pkg::OFS_IMG)  ? img_q
                      : (paddr_i == ppl_pkg::OFS_STAT) ? stat_w
                      : (paddr_i == ppl_pkg::OFS_CNT)  ? wcnt_q : 32'h0000_0000;

  // Answer in the first access cycle; read data fetched at setup
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~hit_w;
      if (setup_w)
        prdata_q <= pwrite_i ? 32'h0000_0000 : rd_w;
    end
  end

  // Software setup of width, features and image length
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= ppl_pkg::CTRL_RST;
      img_q  <= '0;
    end else if (wr_w) begin
      if (paddr_i == ppl_pkg::OFS_CTRL)
        ctrl_q <= ppl_pkg::ppl_ctrl_type'(pwdata_i[5:0]);
      if (paddr_i == ppl_pkg::OFS_IMG)
        img_q <= pwdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  wire [3:0] r_w     = ppl_pkg::ratio_f(ctrl_q); // [RQ1]
  wire       cap_w   = (st_q == ppl_pkg::ST_LOAD) & lrise_w & (ph_q == 4'h0); // [RQ5]
  wire       hold_w  = (st_q == ppl_pkg::ST_POR) | (st_q == ppl_pkg::ST_HOLD);
  wire       stok_w  = cnt_q >= STAT_L;
  wire       uph_w   = ctrl_q.ucl_opt & (cnt_q >= UEN_L); // [RQ20]
  wire       inc_w   = (st_q == ppl_pkg::ST_TAIL) ? lfall_w
                     : (st_q == ppl_pkg::ST_INIT) ? (uph_w ? urise_w : 1'b1)
                     : hold_w ? ~stok_w : 1'b0;
  wire       idone_w = ctrl_q.ucl_opt ? (cnt_q >= UEND_L) : (cnt_q >= INIT_L);

  // Next state; a low request overrides every state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ppl_pkg::ST_POR,
      ppl_pkg::ST_HOLD:  if (stok_w && sts_s[1]) st_d = ppl_pkg::ST_LOAD; // [RQ15]
      ppl_pkg::ST_CLEAR: if (cfg_s[1]) st_d = ppl_pkg::ST_HOLD;
      ppl_pkg::ST_LOAD:  if (wcnt_q == img_q) st_d = ppl_pkg::ST_TAIL; // [RQ11]
      ppl_pkg::ST_TAIL:  if (cnt_q >= TAIL_L) st_d = ppl_pkg::ST_INIT; // [RQ11]
      ppl_pkg::ST_INIT:  if (idone_w) st_d = ppl_pkg::ST_USER; // [RQ19] [RQ21]
      ppl_pkg::ST_USER:  st_d = ppl_pkg::ST_USER;
      default:           st_d = ppl_pkg::ST_POR;
    endcase
    if (!cfg_s[1])
      st_d = ppl_pkg::ST_CLEAR; // [RQ8] [RQ13]
  end

  // Pin drive: status low while clearing, across the step into hold and
  // for the hold time, then released so an external low can stretch it
  always_comb begin
    pins_d.st_oe = (st_d == ppl_pkg::ST_CLEAR) | (st_q == ppl_pkg::ST_CLEAR)
                 | (hold_w & ~stok_w); // [RQ9] [RQ16]
    pins_d.cd_oe = (st_d == ppl_pkg::ST_POR) | (st_d == ppl_pkg::ST_CLEAR)
                 | (st_d == ppl_pkg::ST_HOLD) | (st_d == ppl_pkg::ST_LOAD); // [RQ10]
    pins_d.id_oe = ctrl_q.id_en & ((st_d == ppl_pkg::ST_TAIL)
                 | (st_d == ppl_pkg::ST_INIT)); // [RQ12]
  end

  // State, shared timer and pin flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q   <= ppl_pkg::ST_POR;
      cnt_q  <= '0;
      pins_q <= '{st_oe: 1'b1, cd_oe: 1'b1, id_oe: 1'b0};
      user_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= (st_d != st_q) ? 20'h0_0000 : cnt_q + 20'(inc_w);
      pins_q <= pins_d;
      user_q <= (st_d == ppl_pkg::ST_USER); // [RQ7]
    end
  end

  // ----------------------------------------------------------------------
  // Word capture
  // ----------------------------------------------------------------------
  // Only the first rising edge of each word captures; the other r-1 edges
  // are processing time, so data need not change on them
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q   <= '0;
      wcnt_q <= '0;
      word_q <= '0;
      wv_q   <= 1'b0;
    end else begin
      wv_q <= cap_w;
      if (st_q != ppl_pkg::ST_LOAD) begin
        ph_q <= '0;
        if (st_d == ppl_pkg::ST_CLEAR)
          wcnt_q <= '0;
      end else if (cap_w) begin
        word_q <= d2_q & ppl_pkg::mask_f(ctrl_q.wid); // [RQ6]
        wcnt_q <= wcnt_q + 32'h0000_0001;
        ph_q   <= r_w - 4'h1; // [RQ1]
      end else if (lrise_w) begin
        ph_q <= ph_q - 4'h1; // [RQ3]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o       = prdata_q;
  assign pready_o       = pready_q;
  assign pslverr_o      = pslverr_q;
  assign status_b_o     = 1'b0 & pins_q.st_oe;
  assign status_b_oe_o  = pins_q.st_oe;
  assign load_done_o    = 1'b0 & pins_q.cd_oe;
  assign load_done_oe_o = pins_q.cd_oe;
  assign init_done_o    = 1'b0 & pins_q.id_oe;
  assign init_done_oe_o = pins_q.id_oe;
  assign user_io_o      = user_q;
  assign word_o         = word_q;
  assign word_valid_o   = wv_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_por_low;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_POR && cnt_q < STAT_L) |-> pins_q.st_oe;
  endproperty
  a_por_low: assert property (p_por_low) // [RQ9]
    else $error("status released during power-on delay");

  property p_reprog;
    @(posedge mclk_i) disable iff (!rst_b_i)
      $fell(cfg_s[1]) |-> ##1 (pins_q.st_oe && pins_q.cd_oe);
  endproperty
  a_reprog: assert property (p_reprog) // [RQ13]
    else $error("request low not followed by both lines low");

  property p_cd_load;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_LOAD) |-> pins_q.cd_oe;
  endproperty
  a_cd_load: assert property (p_cd_load) // [RQ10]
    else $error("load complete released while loading");

  property p_user_high;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_USER) |-> !(pins_q.st_oe || pins_q.cd_oe || pins_q.id_oe);
  endproperty
  a_user_high: assert property (p_user_high) // [RQ8]
    else $error("a line driven low in user mode");

  property p_capture;
    @(posedge mclk_i) disable iff (!rst_b_i)
      cap_w |=> word_valid_o && word_o == ($past(d2_q) & ppl_pkg::mask_f(ctrl_q.wid));
  endproperty
  a_capture: assert property (p_capture) // [RQ5] [RQ6]
    else $error("captured word wrong");

  property p_ratio;
    @(posedge mclk_i) disable iff (!rst_b_i)
      cap_w |=> (ph_q == $past(r_w) - 4'h1);
  endproperty
  a_ratio: assert property (p_ratio) // [RQ1]
    else $error("word phase not reloaded from ratio");

  property p_ignore;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_USER) |=> !word_valid_o;
  endproperty
  a_ignore: assert property (p_ignore) // [RQ7]
    else $error("word captured after configuration");

  property p_hold_min;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_HOLD && cnt_q < STAT_L && cfg_s[1]) |=> pins_q.st_oe;
  endproperty
  a_hold_min: assert property (p_hold_min) // [RQ15]
    else $error("status released before hold time");

  property p_tail;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_TAIL && cnt_q == TAIL_L - 20'h1 && lfall_w && cfg_s[1])
        |-> ##2 (st_q == ppl_pkg::ST_INIT);
  endproperty
  a_tail: assert property (p_tail) // [RQ11]
    else $error("init not started after two falling edges");

  property p_init_pin;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == ppl_pkg::ST_INIT && ctrl_q.id_en) |-> pins_q.id_oe;
  endproperty
  a_init_pin: assert property (p_init_pin) // [RQ12]
    else $error("init done released during initialization");

endmodule // ppl_loader

// ==== testbench/ppl_host_model.sv ====
// Purpose: Behavioural configuration host for the parallel load port
// Assumes: Status wire pulled up; load clock period 32 ns
// Notes:   Every word driven is queued so the bench can compare captures
module ppl_host_model (
  // Pins toward the device
  output logic        load_clock_o,
  output logic [31:0] data_o,
  output logic        reprog_b_o,
  // Level of the status wire
  input  wire logic   status_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] sent_q[$];     // Words driven, oldest first
  logic        busy = 1'b0;   // High while a frame is on the lanes

  // ----------------------------------------------------------------------
  // Idle behaviour
  // ----------------------------------------------------------------------
  // Clock parked low; lanes keep toggling so a stray capture never matches
  initial begin
    load_clock_o = 1'b0;
    data_o       = 32'h0000_0000;
    reprog_b_o   = 1'b1;
  end

  always #7 if (!busy) data_o = ~data_o;

  // ----------------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------------
  // A 32 ns period stays under the ceiling of every width
  task automatic clk(input int k);
    repeat (k) begin
      #16 load_clock_o = 1'b1;
      #16 load_clock_o = 1'b0;
    end
  endtask

  // Reconfiguration request held low long enough to count
  task automatic reprog();
    reprog_b_o = 1'b0;
    #2000 reprog_b_o = 1'b1;
  endtask

  // Full frame: each word held for r clocks, so r-1 plus two tail clocks trail the last capture
  task automatic load(input int n, input int r);
    logic [31:0] w;
    wait (status_i === 1'b1);
    #2001.3;
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      if (status_i !== 1'b1) begin
        reprog();
        break;
      end
      w = $urandom;
      data_o = w;
      sent_q.push_back(w);
      clk(r);
    end
    clk(2);
    busy = 1'b0;
  endtask

endmodule  // ppl_host_model

// ==== testbench/ppl_loader_tb.sv ====
// Purpose: Self-checking bench for the parallel passive loader
// Assumes: Scaled hold and init counts; bench is the APB master
// Notes:   Every width with each decompression and security mix is loaded once with random words
module ppl_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int STAT_P = 20;
  localparam int INIT_P = 30;
  localparam int UCLK_P = 4;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        mclk_i = 1'b0;
  logic        rst_b_i;
  logic [7:0]  paddr_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        load_clock;
  logic [31:0] data;
  logic        reprog_b;
  logic        ucl = 1'b0;
  logic        status_b_o;
  logic        status_b_oe_o;
  logic        status_w;
  logic        load_done_o;
  logic        load_done_oe_o;
  logic        init_done_o;
  logic        init_done_oe_o;
  logic        user_io_o;
  logic [31:0] word_o;
  logic        word_valid_o;
  int          err_count = 0;
  int          n_compared = 0;
  logic [1:0]  cur_w = 2'h0;
  logic [31:0] rd;
  logic        er;

  // Open-drain status wire with its pull-up
  assign status_w = status_b_oe_o ? status_b_o : 1'b1;

  always #2 mclk_i = ~mclk_i;
  always #20 ucl = ~ucl;

  ppl_loader #(.STAT_CYC(STAT_P), .INIT_CYC(INIT_P), .UCLK_NUM(UCLK_P)) i_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .load_clock_i(load_clock), .data_i(data), .reprog_b_i(reprog_b),
    .status_b_i(status_w), .user_init_clock_i(ucl), .status_b_o(status_b_o),
    .status_b_oe_o(status_b_oe_o), .load_done_o(load_done_o), .load_done_oe_o(load_done_oe_o),
    .init_done_o(init_done_o), .init_done_oe_o(init_done_oe_o), .user_io_o(user_io_o),
    .word_o(word_o), .word_valid_o(word_valid_o));

  ppl_host_model i_host (
    .load_clock_o(load_clock), .data_o(data), .reprog_b_o(reprog_b), .status_i(status_w));

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic int exp_ratio(input logic [1:0] w, input logic d, input logic s);
    if (w == 2'h2) return d ? 8 : (s ? 4 : 1);
    if (w == 2'h1) return d ? 4 : (s ? 2 : 1);
    return d ? 2 : 1;
  endfunction

  function automatic logic [31:0] exp_mask(input logic [1:0] w);
    return (w == 2'h2) ? 32'hFFFF_FFFF : ((w == 2'h1) ? 32'h0000_FFFF : 32'h0000_00FF);
  endfunction

  // Every capture must match the oldest word the host drove, masked to width
  always @(negedge mclk_i) if (word_valid_o === 1'b1) begin
    if (i_host.sent_q.size() == 0) chk(32'h1, 32'h0);
    else chk(word_o, i_host.sent_q.pop_front() & exp_mask(cur_w));
  end

  // APB transfer; pready, read data and error taken at the edge that ends it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    paddr_i   <= a;
    pwrite_i  <= wr;
    pwdata_i  <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    if (t >= 50) chk(32'h0, 32'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Status held low for the scaled hold time, then let go
  task automatic wait_rel();
    int t;
    t = 0;
    while (status_b_oe_o !== 1'b0 && t < 5000) begin
      @(negedge mclk_i);
      t++;
    end
    chk(32'(t >= STAT_P - 1 && t <= STAT_P + 8), 32'h1);
  endtask

  // ----------------------------------------------------------------------
  // One reconfiguration with a given width and feature mix
  // ----------------------------------------------------------------------
  task automatic run_cfg(input logic [1:0] w, input logic d, input logic s,
                         input logic u, input logic id);
    int n;
    int r;
    int t;
    n = $urandom_range(4, 2);
    r = exp_ratio(w, d, s);
    cur_w = w;
    apb(1'b1, 8'h00, {26'h0, u, id, s, d, w});
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, {26'h0, u, id, s, d, w});
    apb(1'b1, 8'h04, 32'(n));
    fork
      i_host.reprog();
      begin
        repeat (150) @(negedge mclk_i);
        chk({28'h0, status_b_oe_o, load_done_oe_o, load_done_o, init_done_o},
            32'hC);
      end
    join
    wait_rel();
    fork
      i_host.load(n, r);
      begin
        t = 0;
        while (load_done_oe_o !== 1'b0 && t < 20000) begin
          @(negedge mclk_i);
          t++;
        end
        chk(32'(t < 20000), 32'h1);
        chk(32'(i_host.sent_q.size()), 32'h0);
        chk({31'h0, user_io_o}, 32'h0);
        repeat (3) @(negedge mclk_i);
        chk({31'h0, init_done_oe_o}, {31'h0, id});
        t = 0;
        while (user_io_o !== 1'b1 && t < 2000) begin
          @(negedge mclk_i);
          t++;
        end
        // Lower bound only: the two tail edges land some cycles after release
        chk(32'(t < 2000 && t >= (u ? ppl_pkg::UEN_CYC + (UCLK_P - 1) * 10 : INIT_P)),
            32'h1);
      end
    join
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'(n));
    chk({28'h0, status_w, load_done_oe_o, init_done_oe_o, user_io_o}, 32'h9);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_003E);
    i_host.clk(3);
    repeat (8) @(negedge mclk_i);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'(n));
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h5ebb_77ed));
    rst_b_i   = 1'b0;
    paddr_i   = 8'h00;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    pwdata_i  = 32'h0000_0000;
    repeat (16) @(posedge mclk_i);
    chk({30'h0, status_b_oe_o, load_done_oe_o}, 32'h3);
    rst_b_i <= 1'b1;
    wait_rel();
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 8'(a * 4 + (a == 2 ? 4 : 0)), 32'h0);
      chk({31'h0, er}, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    for (int w = 0; w < 3; w++) begin
      for (int f = 0; f < 4; f++) begin
        run_cfg(2'(w), f[1], f[0], f[0] ^ w[0], 1'($urandom_range(1, 0)));
      end
    end
    results();
  end

  // Twelve loads of a few microseconds each fit well inside this span
  initial begin
    #200000;
    err_count++;
    results();
  end

endmodule  // ppl_loader_tb
